// >>> design/lhs_frame_ctl.sv
// Frame controller on clk: synchronises pins, latches straps, detects frames.
// Assumes clk is much faster than scl in two-wire mode and that straps only change while idle.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Frame controller
// ==========================================================================
module lhs_frame_ctl (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Serial pins.
    input wire logic cs_n,
    input wire logic scl,
    input wire logic sda_in,
    // Strap pins.
    input wire logic iface_mode_bit1,
    input wire logic iface_mode_bit2,
    input wire logic address_lsb_pin,
    // Frame control toward the link engine.
    lhs_link_if.ctl link
);
    logic [5:0] pin_raw;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic scl_d, sda_d, busy, start_pend;
    logic next_scl_d, next_sda_d, next_busy, next_start_pend, next_hold, next_lsb;
    logic start_det, stop_det;
    lhs_pkg::lhs_mode_type next_mode;

    assign pin_raw = {address_lsb_pin, iface_mode_bit2, iface_mode_bit1, sda_in, scl, cs_n};

    // Two flip-flops per pin before any logic looks at it.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    sync1[gi] <= lhs_pkg::SYNC_RESET[gi];
                    sync2[gi] <= lhs_pkg::SYNC_RESET[gi];
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // Start and stop are SDA edges seen while SCL stays high.
    assign start_det = (link.mode == lhs_pkg::MODE_I2C) && sync2[1] && scl_d && sda_d && !sync2[2];
    assign stop_det = (link.mode == lhs_pkg::MODE_I2C) && sync2[1] && scl_d && !sda_d && sync2[2];

    // Next frame state; straps are only taken while the link is held.
    always_comb begin
        next_scl_d = sync2[1];
        next_sda_d = sync2[2];
        next_mode = link.mode;
        next_lsb = link.dev_lsb;
        if (link.link_hold) begin
            next_lsb = sync2[5];
            if (!sync2[3] && !sync2[4]) begin
                next_mode = lhs_pkg::MODE_SPI;
            end else if (!sync2[3] && sync2[4]) begin
                next_mode = lhs_pkg::MODE_I2C;
            end else begin
                next_mode = lhs_pkg::MODE_OFF;
            end
        end
        next_busy = start_det ? 1'b1 : (stop_det ? 1'b0 : busy);
        next_start_pend = start_det ? 1'b1 : (sync2[1] ? start_pend : 1'b0);
        case (link.mode)
            lhs_pkg::MODE_SPI: next_hold = sync2[0];
            lhs_pkg::MODE_I2C: next_hold = !next_busy || next_start_pend;
            default: next_hold = 1'b1;
        endcase
    end

    // Frame state registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            busy <= 1'b0;
            start_pend <= 1'b0;
            link.mode <= lhs_pkg::MODE_OFF;
            link.dev_lsb <= 1'b0;
            link.link_hold <= lhs_pkg::LINK_HOLD_RESET;
        end else begin
            scl_d <= next_scl_d;
            sda_d <= next_sda_d;
            busy <= next_busy;
            start_pend <= next_start_pend;
            link.mode <= next_mode;
            link.dev_lsb <= next_lsb;
            link.link_hold <= next_hold;
        end
    end

    chk_cs_high_holds: assert property (@(posedge clk) disable iff (reset)
        (link.mode == lhs_pkg::MODE_SPI && cs_n) [*3] |=> link.link_hold)
        else $error("link not held after chip select rose");
    chk_start_restarts: assert property (@(posedge clk) disable iff (reset)
        start_det |=> link.link_hold && busy)
        else $error("start condition did not restart the link");
    chk_stop_ends: assert property (@(posedge clk) disable iff (reset)
        stop_det && !start_det |=> link.link_hold && !busy)
        else $error("stop condition did not end the frame");
    chk_spi_strap: assert property (@(posedge clk) disable iff (reset)
        (link.link_hold && !iface_mode_bit1 && !iface_mode_bit2) [*4]
        |=> link.mode == lhs_pkg::MODE_SPI)
        else $error("serial mode not taken from straps");
    chk_i2c_strap: assert property (@(posedge clk) disable iff (reset)
        (link.link_hold && !iface_mode_bit1 && iface_mode_bit2) [*4]
        |=> link.mode == lhs_pkg::MODE_I2C)
        else $error("two-wire mode not taken from straps");

endmodule : lhs_frame_ctl

`default_nettype wire

// >>> design/lhs_serial_top.sv
// Host serial front end: clocked serial and two-wire slave, link engine on scl.
// Assumes a display core on clk that executes bytes and answers RAM reads.
//
// Contract
// - Reset leaves pattern RAM alone; host fills it while display is off.
// - During reset drivers and booster read ground; oscillator keeps running.
// - Both mode straps low select clocked serial mode with address pin as code bit.
// - Chip select falling starts a frame with start byte; rising ends it.
// - Only a start byte whose six code bits match opens the transfer.
// - Code lowest bit follows address pin; upper five bits are constant.
// - Seventh start bit selects instruction (0) or pattern RAM data (1).
// - Eighth bit is direction: 00 instr write, 10 RAM write, 11 read, 01 unused.
// - Bytes after the start byte move whole, most significant bit first.
// - RAM reads return two dummy bytes before valid data.
// - Strap bit2 high, bit1 low selects two-wire slave mode.
// - SDA fall with SCL high starts a frame; SDA rise with SCL high ends it.
// - Two-wire mode answers when the first byte's upper six bits match; the code stays silent if the low pair is 01.
// - On a match the ninth bit is pulled low through an open drain.
// - Every correctly received byte after addressing is acknowledged low.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Top module
// ==========================================================================
module lhs_serial_top (
    // System clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Serial link; scl clocks the link engine.
    input wire logic scl,
    input wire logic cs_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap pins.
    input wire logic iface_mode_bit1,
    input wire logic iface_mode_bit2,
    input wire logic address_lsb_pin,
    // Byte stream toward the display core.
    output logic cmd_valid,
    output logic cmd_is_ram,
    output logic [7:0] cmd_byte,
    // Pattern RAM read port.
    output logic ram_rd_req,
    input wire logic [7:0] ram_rd_data,
    // Display drive sources from the core.
    input wire logic [lhs_pkg::COL_COUNT-1:0] column_drive_in,
    input wire logic [lhs_pkg::ROW_COUNT-1:0] row_drive_in,
    input wire logic booster_in,
    input wire logic osc_in,
    // Display pins.
    output logic [lhs_pkg::COL_COUNT-1:0] column_driver_outputs,
    output logic [lhs_pkg::ROW_COUNT-1:0] row_driver_outputs,
    output logic booster_output,
    output logic oscillator_output
);
    lhs_link_if link ();

    // Frame controller on clk.
    lhs_frame_ctl u_frame (
        .clk(clk),
        .reset(reset),
        .cs_n(cs_n),
        .scl(scl),
        .sda_in(sda_in),
        .iface_mode_bit1(iface_mode_bit1),
        .iface_mode_bit2(iface_mode_bit2),
        .address_lsb_pin(address_lsb_pin),
        .link(link)
    );

    // ======================================================================
    // Link engine on scl
    // ======================================================================
    // Link engine state; frame registers cleared by the frame controller's hold, crossing sources by reset.
    lhs_pkg::lhs_link_state_type state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [6:0] shift_in, next_shift_in;
    logic is_read, next_is_read, is_ram, next_is_ram;
    logic [1:0] idx, next_idx;
    logic [7:0] tx, next_tx;
    logic [7:0] rx_byte, next_rx_byte;
    logic rx_is_ram, next_rx_is_ram, rx_tgl, next_rx_tgl, rd_tgl, next_rd_tgl;
    logic [7:0] full;
    logic is_i2c, byte_done, load_evt;
    logic [7:0] rd_hold;

    assign is_i2c = (link.mode == lhs_pkg::MODE_I2C);
    assign full = {shift_in, sda_in};
    assign byte_done = (bit_cnt == lhs_pkg::BIT_LAST);
    assign load_evt = is_i2c ? (bit_cnt == lhs_pkg::BIT_ACK) : byte_done;

    // Next link state: sample on SCL rise, decode start byte, move bytes.
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt + 4'h1;
        next_shift_in = {shift_in[5:0], sda_in};
        next_is_read = is_read;
        next_is_ram = is_ram;
        next_idx = idx;
        next_tx = tx;
        next_rx_byte = rx_byte;
        next_rx_is_ram = rx_is_ram;
        next_rx_tgl = rx_tgl;
        next_rd_tgl = rd_tgl;
        if (byte_done && is_i2c) begin
            next_bit_cnt = lhs_pkg::BIT_ACK;
        end else if (load_evt) begin
            next_bit_cnt = lhs_pkg::BIT_FIRST;
        end
        case (state)
            lhs_pkg::LNK_ADDR: begin
                if (byte_done) begin
                    // Six code bits must match, and the unused pair is refused.
                    if (full[7:2] == {lhs_pkg::DEV_CODE_UPPER, link.dev_lsb}
                            && full[1:0] != lhs_pkg::OP_UNUSED) begin
                        next_state = lhs_pkg::LNK_DATA;
                        next_is_ram = full[1];
                        next_is_read = full[0];
                    end else begin
                        next_state = lhs_pkg::LNK_IGNORE;
                    end
                end
            end
            lhs_pkg::LNK_DATA: begin
                // Written bytes go to the core; nothing here ever clears the RAM.
                if (byte_done && !is_read) begin
                    next_rx_byte = full;
                    next_rx_is_ram = is_ram;
                    next_rx_tgl = !rx_tgl;
                end
            end
            default: next_state = state;
        endcase
        // Read bytes: two dummies, then held RAM data, fetched one byte ahead.
        if (load_evt && next_state == lhs_pkg::LNK_DATA) begin
            if (idx != lhs_pkg::IDX_VALID) begin
                next_idx = idx + 2'h1;
            end
            if (next_is_read) begin
                next_tx = (next_idx == lhs_pkg::IDX_VALID) ? rd_hold : lhs_pkg::DUMMY_BYTE;
                if (next_idx >= lhs_pkg::IDX_FIRST_REQ) begin
                    next_rd_tgl = !rd_tgl;
                end
            end
        end
    end

    // Frame state, cleared whenever the frame controller holds the link.
    always_ff @(posedge scl or posedge link.link_hold) begin
        if (link.link_hold) begin
            state <= lhs_pkg::LNK_ADDR;
            bit_cnt <= lhs_pkg::BIT_FIRST;
            shift_in <= 7'h00;
            is_read <= 1'b0;
            is_ram <= 1'b0;
            idx <= lhs_pkg::IDX_START;
            tx <= lhs_pkg::DUMMY_BYTE;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            is_read <= next_is_read;
            is_ram <= next_is_ram;
            idx <= next_idx;
            tx <= next_tx;
        end
    end

    // Crossing sources survive frame boundaries so no false toggle appears.
    always_ff @(posedge scl or posedge reset) begin
        if (reset) begin
            rx_byte <= 8'h00;
            rx_is_ram <= 1'b0;
            rx_tgl <= 1'b0;
            rd_tgl <= 1'b0;
        end else begin
            rx_byte <= next_rx_byte;
            rx_is_ram <= next_rx_is_ram;
            rx_tgl <= next_rx_tgl;
            rd_tgl <= next_rd_tgl;
        end
    end

    // ======================================================================
    // SDA drive on SCL fall
    // ======================================================================
    logic next_sda_out, next_sda_oe, tx_bit, data_phase, ack_slot;

    // Push-pull in clocked serial mode, pull-low only in two-wire mode.
    always_comb begin
        tx_bit = tx[3'(~bit_cnt[2:0])];
        data_phase = (state == lhs_pkg::LNK_DATA) && is_read && (idx != lhs_pkg::IDX_START)
            && !bit_cnt[3];
        ack_slot = is_i2c && (bit_cnt == lhs_pkg::BIT_ACK) && (state == lhs_pkg::LNK_DATA)
            && (idx == lhs_pkg::IDX_START || !is_read);
        if (is_i2c) begin
            next_sda_out = 1'b0;
            next_sda_oe = ack_slot || (data_phase && !tx_bit);
        end else begin
            next_sda_out = tx_bit;
            next_sda_oe = data_phase;
        end
    end

    // SDA pin registers; released at once when the frame ends.
    always_ff @(negedge scl or posedge link.link_hold) begin
        if (link.link_hold) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= next_sda_out;
            sda_oe <= next_sda_oe;
        end
    end

    // ======================================================================
    // Crossing to clk and core side
    // ======================================================================
    logic rx_s1, rx_s2, rx_s3, rd_s1, rd_s2, rd_s3, rd_capture;
    logic next_cmd_valid, next_cmd_is_ram, next_ram_rd_req;
    logic [7:0] next_cmd_byte, next_rd_hold;

    // Toggle synchronisers; the captured byte is stable for a whole byte time.
    always_comb begin
        next_cmd_valid = rx_s2 ^ rx_s3;
        next_cmd_byte = next_cmd_valid ? rx_byte : cmd_byte;
        next_cmd_is_ram = next_cmd_valid ? rx_is_ram : cmd_is_ram;
        next_ram_rd_req = rd_s2 ^ rd_s3;
        next_rd_hold = rd_capture ? ram_rd_data : rd_hold;
    end

    // Core-side registers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_s3 <= 1'b0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            rd_s3 <= 1'b0;
            rd_capture <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_is_ram <= 1'b0;
            cmd_byte <= 8'h00;
            ram_rd_req <= 1'b0;
            rd_hold <= 8'h00;
        end else begin
            rx_s1 <= rx_tgl;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            rd_s1 <= rd_tgl;
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
            rd_capture <= ram_rd_req;
            cmd_valid <= next_cmd_valid;
            cmd_is_ram <= next_cmd_is_ram;
            cmd_byte <= next_cmd_byte;
            ram_rd_req <= next_ram_rd_req;
            rd_hold <= next_rd_hold;
        end
    end

    // ======================================================================
    // Display pins
    // ======================================================================
    // Drivers and booster are grounded in reset; the oscillator passes through.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            column_driver_outputs <= '0;
            row_driver_outputs <= '0;
            booster_output <= 1'b0;
        end else begin
            column_driver_outputs <= column_drive_in;
            row_driver_outputs <= row_drive_in;
            booster_output <= booster_in;
        end
    end
    assign oscillator_output = osc_in;

    // ======================================================================
    // Checks
    // ======================================================================
    chk_pins_ground_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> column_driver_outputs == '0 && row_driver_outputs == '0
        && !booster_output && oscillator_output == osc_in)
        else $error("display pins not grounded through reset");
    chk_cmd_one_pulse: assert property (@(posedge clk) disable iff (reset)
        cmd_valid |=> !cmd_valid ##1 !cmd_valid)
        else $error("byte strobe longer than one cycle");
    chk_read_capture: assert property (@(posedge clk) disable iff (reset)
        ram_rd_req |=> ##1 rd_hold == $past(ram_rd_data))
        else $error("read data not captured one cycle after request");
    chk_ack_on_match: assert property (@(posedge scl) disable iff (link.link_hold)
        is_i2c && bit_cnt == lhs_pkg::BIT_ACK && state == lhs_pkg::LNK_DATA
        && idx == lhs_pkg::IDX_START |-> sda_oe && !sda_out)
        else $error("address acknowledge missing");
    chk_ignore_quiet: assert property (@(posedge scl) disable iff (link.link_hold)
        state == lhs_pkg::LNK_IGNORE |-> !sda_oe)
        else $error("unselected device drives the data line");
    chk_spi_read_drive: assert property (@(posedge scl) disable iff (link.link_hold)
        !is_i2c && state == lhs_pkg::LNK_DATA && is_read && bit_cnt != lhs_pkg::BIT_FIRST
        |-> sda_oe)
        else $error("read data not driven while selected");
    chk_dummy_zero: assert property (@(posedge scl) disable iff (link.link_hold)
        !is_i2c && is_read && idx != lhs_pkg::IDX_VALID && sda_oe |-> !sda_out)
        else $error("dummy read byte not zero");

    cov_spi_write: cover property (@(posedge clk) disable iff (reset)
        cmd_valid && !cmd_is_ram);
    cov_i2c_ack: cover property (@(posedge scl) disable iff (link.link_hold)
        is_i2c && sda_oe && bit_cnt == lhs_pkg::BIT_ACK);
    cov_valid_read: cover property (@(posedge scl) disable iff (link.link_hold)
        is_read && idx == lhs_pkg::IDX_VALID);

endmodule : lhs_serial_top

`default_nettype wire

// >>> pkg/lhs_link_if.sv
// Frame control carried from the clk-domain frame controller to the link engine.
// Assumes lhs_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Interface
// ==========================================================================
interface lhs_link_if;
    logic link_hold;
    lhs_pkg::lhs_mode_type mode;
    logic dev_lsb;

    modport ctl (output link_hold, output mode, output dev_lsb);
    modport eng (input link_hold, input mode, input dev_lsb);
endinterface : lhs_link_if

`default_nettype wire

// >>> pkg/lhs_pkg.sv
// Shared constants and types for the LCD host serial interface block.
// Assumes the block sits in the host-facing front end of a display controller.
// ==========================================================================
// Package
// ==========================================================================
package lhs_pkg;

    // ======================================================================
    // Display pin widths
    // ======================================================================
    localparam int COL_COUNT = 112;
    localparam int ROW_COUNT = 80;

    // ======================================================================
    // Device code and start byte decoding
    // ======================================================================
    // Upper five bits of the device code; the value is arbitrary.
    localparam logic [4:0] DEV_CODE_UPPER = 5'h15;
    localparam logic [1:0] OP_WR_INSTR = 2'h0;
    localparam logic [1:0] OP_UNUSED = 2'h1;
    localparam logic [1:0] OP_WR_RAM = 2'h2;
    localparam logic [1:0] OP_RD_RAM = 2'h3;

    // ======================================================================
    // Bit and byte counting
    // ======================================================================
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [1:0] IDX_START = 2'h0;
    localparam logic [1:0] IDX_FIRST_REQ = 2'h2;
    localparam logic [1:0] IDX_VALID = 2'h3;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;

    // ======================================================================
    // Reset values
    // ======================================================================
    // Synchroniser reset: cs_n, scl and sda idle high, straps low.
    localparam logic [5:0] SYNC_RESET = 6'h07;
    localparam logic LINK_HOLD_RESET = 1'b1;

    // ======================================================================
    // Types
    // ======================================================================
    typedef enum logic [2:0] {
        LNK_ADDR = 3'h1,
        LNK_DATA = 3'h2,
        LNK_IGNORE = 3'h4
    } lhs_link_state_type;

    typedef enum logic [2:0] {
        MODE_OFF = 3'h1,
        MODE_SPI = 3'h2,
        MODE_I2C = 3'h4
    } lhs_mode_type;

endpackage : lhs_pkg

// >>> tb/lhs_host_model.sv
// Host model: clocked serial frames at 12 ns scl, two-wire frames at a slow scl.
// Assumes a pull-up on sda; the device drives it through sda_out and sda_oe.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host model
// ==========================================================
module lhs_host_model (
    // Host pins and wire level.
    output logic scl,
    output logic cs_n,
    output logic sda_in,
    // Device drive.
    input wire logic sda_out,
    input wire logic sda_oe
);
    logic host_oe = 1'b0;
    logic host_d = 1'b1;
    // Wire level: device first, then host, else the pull-up.
    assign sda_in = sda_oe ? sda_out : (host_oe ? host_d : 1'b1);
    // Clock stands high and select stays off outside frames.
    initial begin
        scl = 1'b1;
        cs_n = 1'b1;
    end
    // One byte each way; the gap after it gives the core time to fetch.
    task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            host_oe = drv;
            host_d = tx[i];
            #6;
            scl = 1'b1;
            rx[i] = sda_in;
            #6;
        end
        host_oe = 1'b0;
        #200;
    endtask : xfer
    // Start byte, then four bytes, inside one select frame.
    task automatic frame(input logic [7:0] sb, input logic rd, input logic [31:0] d,
        output logic [31:0] r);
        logic [7:0] x;
        cs_n = 1'b0;
        #120;
        xfer(sb, 1'b1, x);
        for (int k = 3; k >= 0; k--) begin
            xfer(d[k*8+:8], !rd, x);
            r[k*8+:8] = x;
        end
        cs_n = 1'b1;
        #200;
    endtask : frame
    // Two-wire frame: start, address, one byte, stop; slow scl so clk sees the edges.
    task automatic i2c_frame(input logic [7:0] adr, input logic [7:0] dat,
        output logic [1:0] ack);
        logic [8:0] b;
        host_d = 1'b0;
        host_oe = 1'b1;
        #100;
        for (int n = 1; n >= 0; n--) begin
            b = {n ? adr : dat, 1'b1};
            for (int i = 8; i >= 0; i--) begin
                scl = 1'b0;
                #40;
                host_oe = !b[i];
                #60;
                scl = 1'b1;
                if (i == 0) ack[n] = sda_in;
                #100;
            end
        end
        scl = 1'b0;
        #40;
        host_oe = 1'b1;
        #60;
        scl = 1'b1;
        #100;
        host_oe = 1'b0;
        #200;
    endtask : i2c_frame
endmodule : lhs_host_model
`default_nettype wire

// >>> tb/lhs_serial_top_test.sv
// Testbench for the serial front end in both serial modes.
// Assumes the host model and a small core stand-in answering RAM reads.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Testbench
// ==========================================================
module lhs_serial_top_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic scl, cs_n, sda_in, sda_out, sda_oe, cmd_valid, cmd_is_ram, ram_rd_req;
    logic iface_mode_bit1 = 1'b0;
    logic iface_mode_bit2 = 1'b0;
    logic address_lsb_pin = 1'b0;
    logic booster_in = 1'b1;
    logic osc_in = 1'b0;
    logic booster_output, oscillator_output;
    logic [7:0] cmd_byte;
    logic [7:0] ram_rd_data = 8'h3c;
    logic [lhs_pkg::COL_COUNT-1:0] column_drive_in = '1;
    logic [lhs_pkg::ROW_COUNT-1:0] row_drive_in = '1;
    logic [lhs_pkg::COL_COUNT-1:0] column_driver_outputs;
    logic [lhs_pkg::ROW_COUNT-1:0] row_driver_outputs;
    logic [8:0] seen [$];
    int fail_count = 0;
    int total_checks = 0;
    lhs_serial_top DUT (.clk, .reset, .scl, .cs_n, .sda_in, .sda_out, .sda_oe,
        .iface_mode_bit1, .iface_mode_bit2, .address_lsb_pin, .cmd_valid, .cmd_is_ram,
        .cmd_byte, .ram_rd_req, .ram_rd_data, .column_drive_in, .row_drive_in,
        .booster_in, .osc_in, .column_driver_outputs, .row_driver_outputs,
        .booster_output, .oscillator_output);
    lhs_host_model host (.scl, .cs_n, .sda_in, .sda_out, .sda_oe);
    // Clock, oscillator source, core stand-in and byte monitor.
    always #10 clk = ~clk;
    always @(posedge clk) begin
        osc_in <= ~osc_in;
        if (ram_rd_req === 1'b1) ram_rd_data <= ram_rd_data + 8'h11;
        if (cmd_valid === 1'b1) seen.push_back({cmd_is_ram, cmd_byte});
    end
    // Compares one value and counts it.
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: %h instead of %h", $time, got, exp);
        end
    endtask : check
    // Prints the verdict and stops.
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Sends one frame with the given code bit and op, then counts bytes taken.
    task automatic t_frame(input logic lsb, input logic [1:0] op, input int n);
        logic [31:0] r;
        seen.delete();
        host.frame({lhs_pkg::DEV_CODE_UPPER, lsb, op}, 1'b0, 32'h5aa5_c30f, r);
        repeat (8) @(posedge clk);
        check(9'(seen.size()), 9'(n));
        for (int k = 0; k < n; k++) check(seen[k], {op[1], 8'(32'h5aa5_c30f >> (24 - 8 * k))});
    endtask : t_frame
    // Reads pattern RAM: two dummies, then the stand-in's bytes 3c+11 and 3c+22.
    task automatic t_read();
        logic [31:0] r;
        host.frame({lhs_pkg::DEV_CODE_UPPER, 1'b1, lhs_pkg::OP_RD_RAM}, 1'b1, '0, r);
        check({1'b0, r[31:24]}, {1'b0, lhs_pkg::DUMMY_BYTE});
        check({1'b0, r[23:16]}, {1'b0, lhs_pkg::DUMMY_BYTE});
        check({1'b0, r[15:8]}, 9'h04d);
        check({1'b0, r[7:0]}, 9'h05e);
    endtask : t_read
    // Two-wire mode: a matching address and its byte are acknowledged, a stranger is not.
    task automatic t_i2c();
        logic [1:0] a;
        @(posedge clk);
        iface_mode_bit2 <= 1'b1;
        repeat (8) @(posedge clk);
        seen.delete();
        host.i2c_frame({lhs_pkg::DEV_CODE_UPPER, 1'b1, lhs_pkg::OP_WR_INSTR}, 8'h96, a);
        check({7'h0, a}, 9'h000);
        host.i2c_frame({lhs_pkg::DEV_CODE_UPPER, 1'b0, lhs_pkg::OP_WR_INSTR}, 8'h69, a);
        check({7'h0, a}, 9'h003);
        repeat (8) @(posedge clk);
        check(9'(seen.size()), 9'h001);
        check(seen[0], 9'h096);
    endtask : t_i2c
    // Main sequence: reset, writes, refusals, read.
    initial begin
        repeat (4) @(posedge clk);
        check({7'h0, |{column_driver_outputs, row_driver_outputs, booster_output}, 1'b0}, 9'h0);
        check({8'h0, oscillator_output !== osc_in}, 9'h0);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        check({8'h0, {column_driver_outputs, row_driver_outputs, booster_output}
            !== {column_drive_in, row_drive_in, booster_in}}, 9'h0);
        address_lsb_pin <= 1'b1;
        repeat (4) @(posedge clk);
        t_frame(1'b1, lhs_pkg::OP_WR_INSTR, 4);
        t_frame(1'b1, lhs_pkg::OP_WR_RAM, 4);
        t_frame(1'b0, lhs_pkg::OP_WR_RAM, 0);
        t_frame(1'b1, lhs_pkg::OP_UNUSED, 0);
        t_read();
        t_i2c();
        end_of_test();
    end
    // Watchdog well beyond the length of all frames.
    initial begin
        #60_000;
        fail_count++;
        end_of_test();
    end
endmodule : lhs_serial_top_test
`default_nettype wire
